// ==== hdl/adc_readout_device.sv ====
// converter end: conversion sequencing and serial result output
//
// Contract
// - master: sclk period equals one crystal period
// - slave: host generates the serial clock
// - slave: shift position held across host pauses
// - chip select low: lock, then convert
// - chip select high: abort, tri-state, discard
// - ready line high during conversion
// - ready line low when result waits
// - host treats falling ready as interrupt; code does so in slave mode only, master-mode host just counts clock rises
// - unread result: raise line before update
// - master: line low half clock first
// - shift on falling, sample on rising
// - mode pin low master, high slave
// - result every 69*8*3 crystal periods
// - first settled result after two periods
// - twenty-four clock pulses per read
// - channel select low first, high second
// - slave: host idles clock high
// - offset binary result coding
`timescale 1ns/1ps

module adc_readout_device
  import adc_link_pkg::*;
#(
  parameter int CRYSTAL_CLOCK_HALF  = adc_link_pkg::CRYSTAL_CLOCK_HALF_CYCLES,
  parameter int CONV_CRYSTAL_CLOCK  = adc_link_pkg::CONV_CRYSTAL_CLOCK_PERIODS,
  parameter int LOCK_CRYSTAL_CLOCK  = adc_link_pkg::LOCK_CRYSTAL_CLOCK_PERIODS
) (
  input  wire logic                           clk,
  input  wire logic                           reset,
  adc_link_if.device                          link,
  input  wire logic                           channelSelect,
  input  wire logic [adc_link_pkg::WORD_BITS-1:0] sampleCode,
  output logic                                activeChannel,
  output logic                                converting,
  output logic                                standby
);
  import adc_link_pkg::*;

  // ----------------------------------------------------------------
  // derived counts, in crystal half periods
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(2 * CONV_CRYSTAL_CLOCK - 1);
  localparam logic [CNT_W-1:0] WARN_AT   = CNT_W'(2 * CONV_CRYSTAL_CLOCK - 2);
  localparam logic [CNT_W-1:0] LOCK_LAST = CNT_W'(2 * LOCK_CRYSTAL_CLOCK - 1);

  devState_t              state_q;
  devState_t              state_d;
  logic [CNT_W-1:0]       halfCnt_q;
  logic [CNT_W-1:0]       halfCnt_d;
  logic [CNT_W-1:0]       lockCnt_q;
  logic [CNT_W-1:0]       lockCnt_d;
  logic                   settled_q;
  logic                   settled_d;
  logic [WORD_BITS-1:0]   shift_q;
  logic [WORD_BITS-1:0]   shift_d;
  logic [BIT_W-1:0]       bitCnt_q;
  logic [BIT_W-1:0]       bitCnt_d;
  logic                   sclkOut_q;
  logic                   sclkOut_d;
  logic                   sclkOe_q;
  logic                   sclkOe_d;
  logic                   dout_q;
  logic                   dout_d;
  logic                   doutOe_q;
  logic                   doutOe_d;
  logic                   chan_q;
  logic                   chan_d;
  logic                   sclkPrev_q;
  logic                   sclkPrev_d;
  logic                   conv_q;
  logic                   conv_d;
  logic                   stby_q;
  logic                   stby_d;
  logic                   halfTick;
  logic                   isMaster;
  logic                   sclkFall;
  logic                   sclkRise;
  logic                   running;
  logic                   periodEnd;
  logic                   warnTick;
  logic                   chanChange;

  // ----------------------------------------------------------------
  // crystal timebase, held in phase with chip select
  // ----------------------------------------------------------------
  crystal_clock_tick #(
    .HALF_CYCLES (CRYSTAL_CLOCK_HALF)
  ) u_tick (
    .clk      (clk),
    .reset    (reset),
    .run      (!link.csN),
    .halfTick (halfTick)
  );

  // ----------------------------------------------------------------
  // decode of mode, link edges and conversion timing
  // ----------------------------------------------------------------
  assign isMaster   = (link.modeSel == MODE_MASTER);
  // pins are synchronous here, so edges come from one stored sample
  assign sclkFall   = !isMaster && sclkPrev_q && !link.sclk;
  assign sclkRise   = !isMaster && !sclkPrev_q && link.sclk;
  assign running    = (state_q == DEV_CONVERT) || (state_q == DEV_READY) || (state_q == DEV_SHIFT);
  assign periodEnd  = running && halfTick && (halfCnt_q == CONV_LAST);
  assign warnTick   = running && halfTick && (halfCnt_q == WARN_AT);
  assign chanChange = running && (chan_q != channelSelect);

  // ----------------------------------------------------------------
  // next-state logic for sequencing and the shift path
  // ----------------------------------------------------------------
  always_comb begin
    state_d    = state_q;
    halfCnt_d  = halfCnt_q;
    lockCnt_d  = lockCnt_q;
    settled_d  = settled_q;
    shift_d    = shift_q;
    bitCnt_d   = bitCnt_q;
    sclkOut_d  = sclkOut_q;
    sclkOe_d   = sclkOe_q;
    dout_d     = dout_q;
    doutOe_d   = doutOe_q;
    chan_d     = channelSelect;
    sclkPrev_d = link.sclk;
    conv_d     = 1'b0;
    stby_d     = 1'b0;

    if (link.csN) begin
      // standby: abort, release both pins, lose the held word
      state_d   = DEV_STANDBY;
      halfCnt_d = '0;
      lockCnt_d = '0;
      settled_d = 1'b0;
      shift_d   = '0;
      bitCnt_d  = '0;
      sclkOut_d = 1'b1;
      sclkOe_d  = 1'b0;
      dout_d    = 1'b1;
      doutOe_d  = 1'b0;
      stby_d    = 1'b1;
    end else begin
      sclkOe_d = isMaster;
      doutOe_d = 1'b1;

      // free-running conversion period; a channel change restarts it
      if (chanChange) begin
        halfCnt_d = '0;
        settled_d = 1'b0;
      end else if (running && halfTick) begin
        halfCnt_d = (halfCnt_q == CONV_LAST) ? '0 : bump(halfCnt_q);
        if (periodEnd) begin
          // first period only fills the filter, the second delivers
          settled_d = 1'b1;
        end
      end

      case (state_q)
        DEV_STANDBY: begin
          state_d   = DEV_LOCK;
          lockCnt_d = '0;
          dout_d    = 1'b1;
          sclkOut_d = 1'b1;
        end
        DEV_LOCK: begin
          // multiplier lock modelled as a fixed crystal count
          if (halfTick) begin
            lockCnt_d = bump(lockCnt_q);
            if (lockCnt_q == LOCK_LAST) begin
              state_d   = DEV_CONVERT;
              halfCnt_d = '0;
              settled_d = 1'b0;
            end
          end
        end
        DEV_CONVERT: begin
          dout_d    = 1'b1;
          sclkOut_d = 1'b1;
          conv_d    = 1'b1;
          if (periodEnd && settled_q && !chanChange) begin
            shift_d  = to_offset_binary(sampleCode);
            bitCnt_d = '0;
            dout_d   = 1'b0;
            state_d  = DEV_READY;
          end
        end
        DEV_READY: begin
          dout_d = 1'b0;
          if (warnTick || chanChange) begin
            // unread word: warn the host before the register changes
            dout_d  = 1'b1;
            state_d = DEV_CONVERT;
          end else if (isMaster && halfTick) begin
            // one full half period low has passed since ready fell
            sclkOut_d = 1'b0;
            dout_d    = shift_q[WORD_BITS-1];
            shift_d   = {shift_q[WORD_BITS-2:0], 1'b0};
            state_d   = DEV_SHIFT;
          end else if (sclkFall) begin
            dout_d  = shift_q[WORD_BITS-1];
            shift_d = {shift_q[WORD_BITS-2:0], 1'b0};
            state_d = DEV_SHIFT;
          end
        end
        DEV_SHIFT: begin
          // an update landing mid-read is dropped, the read wins
          if (isMaster) begin
            if (halfTick) begin
              if (!sclkOut_q) begin
                sclkOut_d = 1'b1;
                bitCnt_d  = bitCnt_q + 5'h01;
              end else if (bitCnt_q == ALL_BITS) begin
                // wait one half after the last rise so the host's
                // sample is never raced by the ready edge
                dout_d  = 1'b1;
                state_d = DEV_CONVERT;
              end else begin
                sclkOut_d = 1'b0;
                dout_d    = shift_q[WORD_BITS-1];
                shift_d   = {shift_q[WORD_BITS-2:0], 1'b0};
              end
            end
          end else begin
            // slave: nothing moves without an edge, so pauses hold
            if (sclkFall && (bitCnt_q < ALL_BITS)) begin
              dout_d  = shift_q[WORD_BITS-1];
              shift_d = {shift_q[WORD_BITS-2:0], 1'b0};
            end
            if (sclkRise) begin
              bitCnt_d = bitCnt_q + 5'h01;
              if (bitCnt_q == LAST_BIT) begin
                dout_d  = 1'b1;
                state_d = DEV_CONVERT;
              end
            end
          end
        end
        default: begin
          state_d = DEV_STANDBY;
        end
      endcase
      conv_d = (state_d != DEV_LOCK);
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q    <= DEV_STANDBY;
      halfCnt_q  <= '0;
      lockCnt_q  <= '0;
      settled_q  <= 1'b0;
      shift_q    <= '0;
      bitCnt_q   <= '0;
      sclkOut_q  <= 1'b1;
      sclkOe_q   <= 1'b0;
      dout_q     <= 1'b1;
      doutOe_q   <= 1'b0;
      chan_q     <= 1'b0;
      sclkPrev_q <= 1'b1;
      conv_q     <= 1'b0;
      stby_q     <= 1'b1;
    end else begin
      state_q    <= state_d;
      halfCnt_q  <= halfCnt_d;
      lockCnt_q  <= lockCnt_d;
      settled_q  <= settled_d;
      shift_q    <= shift_d;
      bitCnt_q   <= bitCnt_d;
      sclkOut_q  <= sclkOut_d;
      sclkOe_q   <= sclkOe_d;
      dout_q     <= dout_d;
      doutOe_q   <= doutOe_d;
      chan_q     <= chan_d;
      sclkPrev_q <= sclkPrev_d;
      conv_q     <= conv_d;
      stby_q     <= stby_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flops
  // ----------------------------------------------------------------
  assign link.devSclk   = sclkOut_q;
  assign link.devSclkOe = sclkOe_q;
  assign link.doutData  = dout_q;
  assign link.doutOe    = doutOe_q;
  assign activeChannel  = chan_q;
  assign converting     = conv_q;
  assign standby        = stby_q;
endmodule

// ==== hdl/adc_link_pkg.sv ====
// shared constants, types and helpers for the converter serial link
package adc_link_pkg;

  // ----------------------------------------------------------------
  // clocking
  // ----------------------------------------------------------------
  localparam int CLK_HZ           = 200_000_000;
  localparam int CRYSTAL_CLOCK_HZ          = 32_768;
  // half a crystal period in system cycles, rounded down
  localparam int CRYSTAL_CLOCK_HALF_CYCLES = CLK_HZ / (2 * CRYSTAL_CLOCK_HZ);

  // ----------------------------------------------------------------
  // conversion timing, in crystal periods
  // ----------------------------------------------------------------
  localparam int DECIM_A           = 69;
  localparam int DECIM_B           = 8;
  localparam int DECIM_C           = 3;
  localparam int CONV_CRYSTAL_CLOCK_PERIODS = DECIM_A * DECIM_B * DECIM_C;
  localparam int SETTLE_PERIODS    = 2;
  localparam int LOCK_CRYSTAL_CLOCK_PERIODS = 4;

  // ----------------------------------------------------------------
  // word layout and pin levels
  // ----------------------------------------------------------------
  localparam int         WORD_BITS   = 24;
  localparam int         BATCH_BITS  = 8;
  localparam int         CNT_W       = 16;
  localparam int         BIT_W       = 5;
  localparam logic       MODE_MASTER = 1'b0;
  localparam logic       MODE_SLAVE  = 1'b1;
  localparam logic [4:0] LAST_BIT    = 5'h17;
  localparam logic [4:0] ALL_BITS    = 5'h18;

  // ----------------------------------------------------------------
  // host-side clock generation (slave mode)
  // ----------------------------------------------------------------
  localparam int HOST_HALF_CYCLES  = 10;
  localparam int HOST_PAUSE_CYCLES = 40;

  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    DEV_STANDBY = 6'h01,
    DEV_LOCK    = 6'h02,
    DEV_CONVERT = 6'h04,
    DEV_READY   = 6'h08,
    DEV_SHIFT   = 6'h10
  } devState_t;

  typedef enum logic [4:0] {
    HOST_IDLE  = 5'h01,
    HOST_LOW   = 5'h02,
    HOST_HIGH  = 5'h04,
    HOST_PAUSE = 5'h08
  } hostState_t;

  // two's complement sample to offset binary: flip the sign bit
  function automatic logic [WORD_BITS-1:0] to_offset_binary(input logic [WORD_BITS-1:0] code);
    to_offset_binary = {~code[WORD_BITS-1], code[WORD_BITS-2:0]};
  endfunction

  // one-step counter increment at counter width
  function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] v);
    bump = v + 16'h0001;
  endfunction

endpackage

// ==== hdl/adc_link_if.sv ====
// pin-level link between the converter and its host
`timescale 1ns/1ps

interface adc_link_if;
  logic csN;
  logic modeSel;
  logic hostSclk;
  logic devSclk;
  logic devSclkOe;
  logic doutData;
  logic doutOe;
  logic sclk;
  logic doutRdy;

  // ----------------------------------------------------------------
  // wire resolution: device drives when enabled, else host / pull-up
  // ----------------------------------------------------------------
  assign sclk    = devSclkOe ? devSclk : hostSclk;
  assign doutRdy = doutOe ? doutData : 1'b1;

  modport device (
    input  csN,
    input  modeSel,
    input  sclk,
    output devSclk,
    output devSclkOe,
    output doutData,
    output doutOe
  );

  modport host (
    output csN,
    output modeSel,
    output hostSclk,
    input  sclk,
    input  doutRdy
  );
endinterface

// ==== hdl/crystal_clock_tick.sv ====
// crystal half-period tick generator
`timescale 1ns/1ps

module crystal_clock_tick #(
  parameter int HALF_CYCLES = 3051
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic run,
  output logic      halfTick
);
  import adc_link_pkg::*;

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             tick_q;
  logic             tick_d;

  // ----------------------------------------------------------------
  // divider: restarts whenever run drops so phase follows chip select
  // ----------------------------------------------------------------
  always_comb begin
    cnt_d  = cnt_q;
    tick_d = 1'b0;
    if (!run) begin
      cnt_d = '0;
    end else if (cnt_q == CNT_W'(HALF_CYCLES - 1)) begin
      cnt_d  = '0;
      tick_d = 1'b1;
    end else begin
      cnt_d = bump(cnt_q);
    end
  end

  // registers
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign halfTick = tick_q;
endmodule

// ==== hdl/adc_readout_host.sv ====
// host end: selects the converter and collects 24-bit results
`timescale 1ns/1ps

module adc_readout_host
  import adc_link_pkg::*;
(
  input  wire logic                               clk,
  input  wire logic                               reset,
  adc_link_if.host                                link,
  input  wire logic                               enable,
  input  wire logic                               slaveMode,
  input  wire logic                               batchPause,
  output logic [adc_link_pkg::WORD_BITS-1:0]      result,
  output logic                                    resultStrobe,
  output logic                                    busy
);
  import adc_link_pkg::*;

  localparam logic [CNT_W-1:0] HALF_LAST  = CNT_W'(HOST_HALF_CYCLES - 1);
  localparam logic [CNT_W-1:0] PAUSE_LAST = CNT_W'(HOST_PAUSE_CYCLES - 1);

  hostState_t           state_q;
  hostState_t           state_d;
  logic [CNT_W-1:0]     timer_q;
  logic [CNT_W-1:0]     timer_d;
  logic [BIT_W-1:0]     bitCnt_q;
  logic [BIT_W-1:0]     bitCnt_d;
  logic [WORD_BITS-1:0] shift_q;
  logic [WORD_BITS-1:0] shift_d;
  logic [WORD_BITS-1:0] result_q;
  logic [WORD_BITS-1:0] result_d;
  logic                 strobe_q;
  logic                 strobe_d;
  logic                 csN_q;
  logic                 csN_d;
  logic                 mode_q;
  logic                 mode_d;
  logic                 sclk_q;
  logic                 sclk_d;
  logic                 rdyPrev_q;
  logic                 sclkPrev_q;
  logic                 busy_q;
  logic                 busy_d;
  logic                 rdyFall;
  logic                 lineRise;

  // edges of the converter's lines
  assign rdyFall  = rdyPrev_q && !link.doutRdy;
  assign lineRise = !sclkPrev_q && link.sclk;

  // ----------------------------------------------------------------
  // next-state: slave clocking or master-clock capture
  // ----------------------------------------------------------------
  always_comb begin
    state_d  = state_q;
    timer_d  = timer_q;
    bitCnt_d = bitCnt_q;
    shift_d  = shift_q;
    result_d = result_q;
    strobe_d = 1'b0;
    csN_d    = !enable;
    mode_d   = slaveMode ? MODE_SLAVE : MODE_MASTER;
    sclk_d   = sclk_q;
    busy_d   = 1'b0;

    if (csN_q) begin
      state_d  = HOST_IDLE;
      bitCnt_d = '0;
      sclk_d   = 1'b1;
    end else if (mode_q == MODE_MASTER) begin
      sclk_d = 1'b1;
      if (lineRise) begin
        shift_d  = {shift_q[WORD_BITS-2:0], link.doutRdy};
        bitCnt_d = (bitCnt_q == LAST_BIT) ? '0 : bitCnt_q + 5'h01;
        if (bitCnt_q == LAST_BIT) begin
          result_d = {shift_q[WORD_BITS-2:0], link.doutRdy};
          strobe_d = 1'b1;
        end
      end
    end else begin
      busy_d = (state_q != HOST_IDLE);
      case (state_q)
        HOST_IDLE: begin
          sclk_d = 1'b1;                  // idle high between transfers
          if (rdyFall) begin              // falling ready acts as interrupt
            state_d  = HOST_LOW;
            sclk_d   = 1'b0;              // host owns the clock in slave mode
            timer_d  = '0;
            bitCnt_d = '0;
          end
        end
        HOST_LOW: begin
          timer_d = bump(timer_q);
          if (timer_q == HALF_LAST) begin
            sclk_d   = 1'b1;
            shift_d  = {shift_q[WORD_BITS-2:0], link.doutRdy};
            bitCnt_d = bitCnt_q + 5'h01;
            timer_d  = '0;
            state_d  = HOST_HIGH;
          end
        end
        HOST_HIGH: begin
          timer_d = bump(timer_q);
          if (timer_q == HALF_LAST) begin
            timer_d = '0;
            if (bitCnt_q == ALL_BITS) begin
              result_d = shift_q;
              strobe_d = 1'b1;
              state_d  = HOST_IDLE;
            end else if (batchPause && (bitCnt_q[2:0] == 3'h0)) begin
              state_d = HOST_PAUSE;       // byte-wise batches
            end else begin
              sclk_d  = 1'b0;
              state_d = HOST_LOW;
            end
          end
        end
        HOST_PAUSE: begin
          timer_d = bump(timer_q);
          if (timer_q == PAUSE_LAST) begin
            timer_d = '0;
            sclk_d  = 1'b0;
            state_d = HOST_LOW;
          end
        end
        default: begin
          state_d = HOST_IDLE;
        end
      endcase
    end
  end

  // registers
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q    <= HOST_IDLE;
      timer_q    <= '0;
      bitCnt_q   <= '0;
      shift_q    <= '0;
      result_q   <= '0;
      strobe_q   <= 1'b0;
      csN_q      <= 1'b1;
      mode_q     <= MODE_SLAVE;
      sclk_q     <= 1'b1;
      rdyPrev_q  <= 1'b1;
      sclkPrev_q <= 1'b1;
      busy_q     <= 1'b0;
    end else begin
      state_q    <= state_d;
      timer_q    <= timer_d;
      bitCnt_q   <= bitCnt_d;
      shift_q    <= shift_d;
      result_q   <= result_d;
      strobe_q   <= strobe_d;
      csN_q      <= csN_d;
      mode_q     <= mode_d;
      sclk_q     <= sclk_d;
      rdyPrev_q  <= link.doutRdy;
      sclkPrev_q <= link.sclk;
      busy_q     <= busy_d;
    end
  end

  assign link.csN      = csN_q;
  assign link.modeSel  = mode_q;
  assign link.hostSclk = sclk_q;
  assign result        = result_q;
  assign resultStrobe  = strobe_q;
  assign busy          = busy_q;
endmodule

// ==== verification/adc_link_props.sv ====
// concurrent checks on the converter link wires
`timescale 1ns/1ps

module adc_link_props #(
  parameter int CRYSTAL_CLOCK_HALF = 4,
  parameter int PERIOD    = 320
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic csN,
  input wire logic modeSel,
  input wire logic hostSclk,
  input wire logic sclk,
  input wire logic devSclkOe,
  input wire logic doutOe,
  input wire logic doutRdy
);
  // ----------------------------------------------------------------
  // word tracking
  // ----------------------------------------------------------------
  logic [4:0]  cnt_q, cnt_d;
  logic [15:0] gap_q, gap_d;
  logic        seen_q, seen_d, rdy_q, sclk_q, rdyFall, sclkRise;
  // a ready fall is a drop while the clock idles high, never a data bit
  assign rdyFall  = rdy_q && !doutRdy && sclk && !csN;
  assign sclkRise = sclk && !sclk_q;
  // rises per word, and spacing of master-mode ready falls
  always_comb begin
    cnt_d  = (rdyFall || csN) ? 5'h00 : cnt_q + {4'h0, sclkRise};
    gap_d  = rdyFall ? 16'h0000 : gap_q + 16'h0001;
    seen_d = !csN && !modeSel && (seen_q || rdyFall);
  end
  // helper flops; edge history needs no reset
  always_ff @(posedge clk) begin
    cnt_q  <= reset ? 5'h00 : cnt_d;
    gap_q  <= reset ? 16'h0000 : gap_d;
    seen_q <= reset ? 1'b0 : seen_d;
    rdy_q  <= doutRdy;
    sclk_q <= sclk;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence lastRise;
    sclkRise && cnt_q == 5'h17;
  endsequence
  sequence leadHigh;
    sclk [*4];
  endsequence
  a_standby_release: assert property (csN [*2] |-> !doutOe && !devSclkOe)
    else $error("pins still driven in standby");
  a_master_clock_only: assert property (devSclkOe |-> !modeSel)
    else $error("device drives clock outside master mode");
  // chip select high may cut a low half short, so it drops the attempt
  a_half_period: assert property (disable iff (reset || csN) $fell(sclk) && devSclkOe |-> ##CRYSTAL_CLOCK_HALF $rose(sclk))
    else $error("master clock half period wrong");
  a_ready_lead: assert property (rdyFall && !modeSel |-> leadHigh)
    else $error("clock started too soon after ready");
  a_word_count: assert property (cnt_q <= 5'h18)
    else $error("more than twenty-four clock rises");
  a_word_end: assert property (lastRise |-> ##[1:5] doutRdy)
    else $error("line not returned high after last bit");
  a_bit_stable: assert property (sclk && sclk_q && !csN && cnt_q != 5'h00 && cnt_q < 5'h18 |-> $stable(doutRdy))
    else $error("data moved while clock high");
  a_host_idle: assert property (modeSel && cnt_q == 5'h18 |-> hostSclk)
    else $error("host clock not idling high");
  a_result_rate: assert property (rdyFall && seen_q |-> gap_q == 16'(PERIOD - 1))
    else $error("result spacing wrong");
endmodule

// ==== verification/adc_serial_readout_tb.sv ====
// self-checking bench, both link ends joined
`timescale 1ns/1ps

module adc_serial_readout_tb;
  import adc_link_pkg::*;
  // ----------------------------------------------------------------
  // set-up
  // ----------------------------------------------------------------
  typedef struct {logic m; logic p; logic [23:0] s; logic [23:0] r;} row_t;
  logic                 clk, reset, channelSelect, enable, slaveMode, batchPause;
  logic                 activeChannel, converting, standby, resultStrobe, busy;
  logic [WORD_BITS-1:0] sampleCode, result;
  int                   nMismatch, cmpCount, n;
  // mode, pause, sample, expected word
  row_t rows[4] = '{'{1'b0, 1'b0, 24'h000000, 24'h800000}, '{1'b0, 1'b0, 24'h7fffff, 24'hffffff},
                    '{1'b1, 1'b0, 24'h800000, 24'h000000}, '{1'b1, 1'b1, 24'h5a3c96, 24'hda3c96}};
  adc_link_if adc_link_if_i ();
  adc_readout_device #(.CRYSTAL_CLOCK_HALF(4), .CONV_CRYSTAL_CLOCK(40), .LOCK_CRYSTAL_CLOCK(2)) adc_readout_device_i (.clk(clk),
    .reset(reset), .link(adc_link_if_i.device), .channelSelect(channelSelect), .sampleCode(sampleCode),
    .activeChannel(activeChannel), .converting(converting), .standby(standby));
  adc_readout_host adc_readout_host_i (.clk(clk), .reset(reset), .link(adc_link_if_i.host), .enable(enable),
    .slaveMode(slaveMode), .batchPause(batchPause), .result(result), .resultStrobe(resultStrobe), .busy(busy));
  adc_link_props #(.CRYSTAL_CLOCK_HALF(4), .PERIOD(320)) adc_link_props_i (.clk(clk), .reset(reset),
    .csN(adc_link_if_i.csN), .modeSel(adc_link_if_i.modeSel), .hostSclk(adc_link_if_i.hostSclk),
    .sclk(adc_link_if_i.sclk), .devSclkOe(adc_link_if_i.devSclkOe), .doutOe(adc_link_if_i.doutOe),
    .doutRdy(adc_link_if_i.doutRdy));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk1(input logic got, input logic exp);
    cmpCount++;
    if (got !== exp) begin
      nMismatch++;
      $display("mismatch at %0t: bit %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic chk24(input logic [23:0] got, input logic [23:0] exp);
    cmpCount++;
    if (got !== exp) begin
      nMismatch++;
      $display("mismatch at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("counts: %0d mismatches, %0d comparisons", nMismatch, cmpCount);
    if (nMismatch == 0 && cmpCount > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // bounded wait for ready low (rdy) or a result strobe; n gives cycles spent
  task automatic wait_on(input bit rdy);
    n = 0;
    while ((rdy ? !adc_link_if_i.doutRdy : resultStrobe) !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 3000) begin
        nMismatch++;
        $display("mismatch at %0t: wait ran out", $time);
        finish_test();
      end
    end
  endtask
  initial begin
    reset = 1'b1;
    enable = 1'b0;
    channelSelect = 1'b0;
    slaveMode = 1'b0;
    batchPause = 1'b0;
    sampleCode = 24'h000000;
    repeat (3) @(negedge clk);
    chk1(standby, 1'b1);
    reset = 1'b0;
    // table rows; master rows stay selected for a second result
    foreach (rows[i]) begin
      slaveMode = rows[i].m;
      batchPause = rows[i].p;
      sampleCode = rows[i].s;
      @(negedge clk);
      enable = 1'b1;
      wait_on(1'b1);
      if (i == 0) chk1(n inside {[650:675]}, 1'b1);
      repeat (3) @(negedge clk);
      chk1(busy, rows[i].m);
      wait_on(1'b0);
      chk24(result, rows[i].r);
      // the last bit may be low: let the line return high before waiting
      if (!rows[i].m) begin
        repeat (10) @(negedge clk);
        wait_on(1'b1);
      end
      enable = 1'b0;
      repeat (4) @(negedge clk);
      chk1(adc_link_if_i.doutRdy, 1'b1);
    end
    channelSelect = 1'b1;
    repeat (3) @(negedge clk);
    chk1(activeChannel, 1'b1);
    // abort mid-read, then the next result must wait two full periods again
    slaveMode = 1'b0;
    enable = 1'b1;
    repeat (100) @(negedge clk);
    chk1(converting, 1'b1);
    chk1(adc_link_if_i.doutRdy, 1'b1);
    wait_on(1'b1);
    chk1(adc_link_if_i.doutRdy, 1'b0);
    repeat (60) @(negedge clk);
    enable = 1'b0;
    repeat (3) @(negedge clk);
    chk1(adc_link_if_i.devSclkOe, 1'b0);
    enable = 1'b1;
    wait_on(1'b1);
    chk1(n inside {[650:675]}, 1'b1);
    finish_test();
  end
endmodule
